/* File: shared/irqp_defines.vh */
`ifndef IRQP_DEFINES_VH
`define IRQP_DEFINES_VH

`define IRQP_PRIO_ADDR     8'hB8
`define IRQP_IE_ADDR       8'hA8
`define IRQP_PRIO_RESET    8'h80
`define IRQP_IE_RESET      8'h00
`define IRQP_RSVD_MASK     8'h80
`define IRQP_NUM_SRC       7
`define IRQP_BIT_RSVD      7
`define IRQP_BIT_SPI       6
`define IRQP_BIT_T2        5
`define IRQP_BIT_UART      4
`define IRQP_BIT_T1        3
`define IRQP_BIT_EX1       2
`define IRQP_BIT_T0        1
`define IRQP_BIT_EX0       0
`define IRQP_BIT_GIE       7
`define IRQP_LVL_NONE      2'b00
`define IRQP_LVL_LOW       2'b01
`define IRQP_LVL_HIGH      2'b10

`endif

/* File: rtl/irqp_select.v */
`include "irqp_defines.vh"

// ****************************************************************
// Fixed-order pick of the lowest-numbered request in one level.
// ****************************************************************
module irqp_select #(
    parameter N = `IRQP_NUM_SRC
) (
    input  wire [N-1:0] req,
    output reg          any,
    output reg  [2:0]   idx
);
    integer i;
    always @* begin
        any = 1'b0;
        idx = 3'b000;
        for (i = N - 1; i >= 0; i = i - 1) begin
            if (req[i]) begin
                any = 1'b1;
                idx = i[2:0];
            end
        end
    end
endmodule // irqp_select

/* File: rtl/irqp_prio_reg.v */
`include "irqp_defines.vh"

// Behaviour
// R1: priority register at 0xB8, bit access
// R2: bit 6 selects SPI priority
// R3: bit 5 selects timer two priority
// R4: bit 4 selects UART priority
// R5: bit 3 selects timer one priority
// R6: bit 2 selects external input one priority
// R7: bit 1 selects timer zero priority
// R8: bit 0 selects external input zero priority
// R9: bit 7 reserved, read-only, reads one
// R10: high priority served first, may preempt low
// R11: priority acts only under global enable
module irqp_prio_reg #(
    parameter N = `IRQP_NUM_SRC
) (
    input  wire         mclk,
    input  wire         reset,
    input  wire [7:0]   sfr_addr,
    input  wire [7:0]   sfr_wdata,
    input  wire         sfr_wr,
    input  wire         sfr_rd,
    input  wire         sfr_bit_wr,
    input  wire [2:0]   sfr_bit_sel,
    input  wire         sfr_bit_val,
    input  wire [N-1:0] irq_pending,
    input  wire [N-1:0] irq_enable,
    input  wire         global_irq_enable,
    input  wire         irq_ack,
    input  wire         irq_return,
    output reg  [7:0]   sfr_rdata_r,
    output reg          sfr_hit_r,
    output reg  [7:0]   core_interrupt_priority_r,
    output reg          irq_req_r,
    output reg  [2:0]   irq_src_r,
    output reg          irq_high_r,
    output reg  [1:0]   active_lvl_r
);

    // ****************************************************************
    // Register write path.
    // ****************************************************************
    // The address decode is shared by the write and the read paths.
    function prio_sel;
        input [7:0] addr;
        begin
            prio_sel = (addr == `IRQP_PRIO_ADDR);
        end
    endfunction

    // Next value of one writable cell; a byte write wins over a bit write.
    function cell_next;
        input         cur;
        input integer pos;
        input         byte_we;
        input         byte_val;
        input         bit_we;
        input [2:0]   bit_sel;
        input         bit_val;
        begin
            if (byte_we) begin
                cell_next = byte_val;
            end else if (bit_we && (bit_sel == pos[2:0])) begin
                cell_next = bit_val;
            end else begin
                cell_next = cur;
            end
        end
    endfunction

    wire       byte_we_w = prio_sel(sfr_addr) && sfr_wr;             // [R1]
    wire       bit_we_w  = prio_sel(sfr_addr) && sfr_bit_wr;         // [R1]
    wire       rd_hit_w  = prio_sel(sfr_addr) && sfr_rd;             // [R1]
    wire [7:0] core_interrupt_priority_nxt;

    genvar g;
    generate
        for (g = 0; g < `IRQP_BIT_RSVD; g = g + 1) begin : g_cell
            assign core_interrupt_priority_nxt[g] = cell_next(core_interrupt_priority_r[g], g,
                                                              byte_we_w, sfr_wdata[g],
                                                              bit_we_w, sfr_bit_sel, sfr_bit_val);
        end
    endgenerate

    // Reserved bit ignores writes and always holds one.
    assign core_interrupt_priority_nxt[`IRQP_BIT_RSVD] = 1'b1;         // [R9]

    always @(posedge mclk or posedge reset) begin
        if (reset) begin
            core_interrupt_priority_r <= `IRQP_PRIO_RESET;        // [R9]
        end else begin
            core_interrupt_priority_r <= core_interrupt_priority_nxt;
        end
    end

    // ****************************************************************
    // Read path.
    // ****************************************************************
    // Read data shows the value held before a write in the same cycle.
    always @(posedge mclk or posedge reset) begin
        if (reset) begin
            sfr_rdata_r <= 8'h00;
            sfr_hit_r   <= 1'b0;
        end else begin
            sfr_hit_r   <= rd_hit_w;                                  // [R1]
            sfr_rdata_r <= rd_hit_w ? core_interrupt_priority_r : 8'h00;
        end
    end

    // ****************************************************************
    // Priority resolution.
    // ****************************************************************
    wire serial_periph_prio_sel = core_interrupt_priority_r[`IRQP_BIT_SPI];  // [R2]
    wire timer_two_prio_sel     = core_interrupt_priority_r[`IRQP_BIT_T2];   // [R3]
    wire uart_prio_sel          = core_interrupt_priority_r[`IRQP_BIT_UART]; // [R4]
    wire timer_one_prio_sel     = core_interrupt_priority_r[`IRQP_BIT_T1];   // [R5]
    wire ext_irq_one_prio_sel   = core_interrupt_priority_r[`IRQP_BIT_EX1];  // [R6]
    wire timer_zero_prio_sel    = core_interrupt_priority_r[`IRQP_BIT_T0];   // [R7]
    wire ext_irq_zero_prio_sel  = core_interrupt_priority_r[`IRQP_BIT_EX0];  // [R8]
    wire [`IRQP_NUM_SRC-1:0] prio_all_w = {
        serial_periph_prio_sel,
        timer_two_prio_sel,
        uart_prio_sel,
        timer_one_prio_sel,
        ext_irq_one_prio_sel,
        timer_zero_prio_sel,
        ext_irq_zero_prio_sel
    };
    wire [N-1:0] prio_w  = prio_all_w[N-1:0];
    wire [N-1:0] live_w  = irq_pending & irq_enable & {N{global_irq_enable}}; // [R11]
    wire [N-1:0] hreq_w  = live_w & prio_w;
    wire [N-1:0] lreq_w  = live_w & ~prio_w;
    wire         hany_w;
    wire         lany_w;
    wire [2:0]   hidx_w;
    wire [2:0]   lidx_w;

    irqp_select #(.N(N)) u_high (
        .req (hreq_w),
        .any (hany_w),
        .idx (hidx_w)
    );

    irqp_select #(.N(N)) u_low (
        .req (lreq_w),
        .any (lany_w),
        .idx (lidx_w)
    );

    // ****************************************************************
    // Request selection and handler level.
    // ****************************************************************
    reg       req_nxt;
    reg [2:0] src_nxt;
    reg       high_nxt;
    reg [1:0] lvl_nxt;
    reg       nested_nxt;
    reg       low_nested_r;

    always @* begin
        req_nxt  = 1'b0;
        src_nxt  = 3'b000;
        high_nxt = 1'b0;
        lvl_nxt  = active_lvl_r;
        nested_nxt = low_nested_r;
        // A high request may interrupt a low handler but nothing else.
        if (hany_w && (active_lvl_r != `IRQP_LVL_HIGH)) begin
            req_nxt  = 1'b1;                                      // [R10]
            src_nxt  = hidx_w;
            high_nxt = 1'b1;
        end else if (lany_w && (active_lvl_r == `IRQP_LVL_NONE)) begin
            req_nxt  = 1'b1;
            src_nxt  = lidx_w;
        end
        case (active_lvl_r)
            `IRQP_LVL_NONE: begin
                if (irq_ack && irq_req_r) begin
                    lvl_nxt = irq_high_r ? `IRQP_LVL_HIGH : `IRQP_LVL_LOW;
                end
            end
            `IRQP_LVL_LOW: begin
                if (irq_ack && irq_req_r && irq_high_r) begin
                    lvl_nxt = `IRQP_LVL_HIGH;                     // [R10]
                    nested_nxt = 1'b1;
                end else if (irq_return) begin
                    lvl_nxt = `IRQP_LVL_NONE;
                end
            end
            `IRQP_LVL_HIGH: begin
                // A high handler that preempted a low one resumes the low level.
                if (irq_return) begin
                    lvl_nxt    = low_nested_r ? `IRQP_LVL_LOW : `IRQP_LVL_NONE; // [R10]
                    nested_nxt = 1'b0;
                end
            end
            default: begin
                lvl_nxt = `IRQP_LVL_NONE;
                nested_nxt = 1'b0;
            end
        endcase
        if (irq_ack) begin
            req_nxt = 1'b0;
        end
    end

    // ****************************************************************
    // Request outputs.
    // ****************************************************************
    always @(posedge mclk or posedge reset) begin
        if (reset) begin
            irq_req_r    <= 1'b0;
            irq_src_r    <= 3'b000;
            irq_high_r   <= 1'b0;
            active_lvl_r <= `IRQP_LVL_NONE;
            low_nested_r <= 1'b0;
        end else begin
            irq_req_r    <= req_nxt;
            irq_src_r    <= src_nxt;
            irq_high_r   <= high_nxt;
            active_lvl_r <= lvl_nxt;
            low_nested_r <= nested_nxt;
        end
    end

endmodule // irqp_prio_reg

/* File: testbench/irqp_prio_props.sv */
`include "irqp_defines.vh"
// ****
// Checker for the priority register ports.
// ****
module irqp_prio_props #(
    parameter N = `IRQP_NUM_SRC
) (
    input wire         mclk,
    input wire         reset,
    input wire         sfr_wr,
    input wire         sfr_rd,
    input wire         sfr_bit_wr,
    input wire         sfr_bit_val,
    input wire         sfr_hit_r,
    input wire         global_irq_enable,
    input wire         irq_ack,
    input wire         irq_return,
    input wire         irq_req_r,
    input wire         irq_high_r,
    input wire [7:0]   sfr_addr,
    input wire [7:0]   sfr_wdata,
    input wire [7:0]   sfr_rdata_r,
    input wire [7:0]   core_interrupt_priority_r,
    input wire [2:0]   sfr_bit_sel,
    input wire [N-1:0] irq_pending,
    input wire [N-1:0] irq_enable,
    input wire [1:0]   active_lvl_r
);
    default clocking @(posedge mclk); endclocking
    default disable iff (reset);
    wire [7:0] p = core_interrupt_priority_r;
    wire hit = sfr_addr == `IRQP_PRIO_ADDR;
    wire hp = |(irq_pending & irq_enable & p[N-1:0]);
    // Remembers that a low handler runs beneath the current level.
    logic saw_low_r;
    always @(posedge mclk or posedge reset) begin
        if (reset) saw_low_r <= 1'b0;
        else if (active_lvl_r == `IRQP_LVL_LOW) saw_low_r <= 1'b1;
        else if (active_lvl_r == `IRQP_LVL_NONE) saw_low_r <= 1'b0;
    end
    sequence nest_ret_s; active_lvl_r == `IRQP_LVL_HIGH && saw_low_r && irq_return; endsequence
    sequence ack_s; irq_ack && irq_req_r; endsequence
    sequence served_s; !irq_req_r && active_lvl_r != 2'b00; endsequence
    rsvd_one_a: assert property (p[7]) else $error("reserved bit low");
    byte_wr_a: assert property (sfr_wr && hit |=> p == ($past(sfr_wdata) | 8'h80))
        else $error("byte write lost");
    bit_wr_a: assert property (sfr_bit_wr && !sfr_wr && hit && sfr_bit_sel != 3'h7
        |=> p[$past(sfr_bit_sel)] == $past(sfr_bit_val)) else $error("bit write lost");
    miss_wr_a: assert property ((sfr_wr || sfr_bit_wr) && !hit |=> $stable(p))
        else $error("foreign write taken");
    rd_data_a: assert property (sfr_rd && hit |=> sfr_hit_r && sfr_rdata_r == $past(p))
        else $error("read data wrong");
    rd_idle_a: assert property (!sfr_rd |=> sfr_rdata_r == 8'h00 && !sfr_hit_r)
        else $error("read data not idle");
    gie_off_a: assert property (!global_irq_enable |=> !irq_req_r)
        else $error("request with global enable low");
    high_pick_a: assert property (irq_req_r && $past(hp) |-> irq_high_r)
        else $error("low picked over high");
    ack_serve_a: assert property (ack_s |=> served_s) else $error("ack not taken");
    nest_ret_a: assert property (nest_ret_s |=> active_lvl_r == `IRQP_LVL_LOW)
        else $error("preempted low level lost");
endmodule // irqp_prio_props
bind irqp_prio_reg irqp_prio_props #(.N(N)) u_props (
    .mclk                      (mclk),
    .reset                     (reset),
    .sfr_wr                    (sfr_wr),
    .sfr_rd                    (sfr_rd),
    .sfr_bit_wr                (sfr_bit_wr),
    .sfr_bit_val               (sfr_bit_val),
    .sfr_hit_r                 (sfr_hit_r),
    .global_irq_enable         (global_irq_enable),
    .irq_ack                   (irq_ack),
    .irq_return                (irq_return),
    .irq_req_r                 (irq_req_r),
    .irq_high_r                (irq_high_r),
    .sfr_addr                  (sfr_addr),
    .sfr_wdata                 (sfr_wdata),
    .sfr_rdata_r               (sfr_rdata_r),
    .core_interrupt_priority_r (core_interrupt_priority_r),
    .sfr_bit_sel               (sfr_bit_sel),
    .irq_pending               (irq_pending),
    .irq_enable                (irq_enable),
    .active_lvl_r              (active_lvl_r)
);

/* File: testbench/interrupt_priority_register_tb.sv */
`include "irqp_defines.vh"
module interrupt_priority_register_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk = 0, reset = 1, sfr_wr = 0, sfr_rd = 0, sfr_bit_wr = 0, sfr_bit_val = 0, snap = 0;
    logic global_irq_enable = 0, irq_ack = 0, irq_return = 0, sfr_hit_r, irq_req_r, irq_high_r;
    logic [7:0] sfr_addr = '0, sfr_wdata = '0, sfr_rdata_r, core_interrupt_priority_r, e;
    logic [7:0] s = 8'h34, q[$], qi[$];
    logic [2:0] sfr_bit_sel = '0, irq_src_r;
    logic [6:0] irq_pending = '0, irq_enable = '0;
    logic [1:0] active_lvl_r;
    int fails = 0, num_checks = 0, i;
    wire  [7:0] stat = {irq_high_r, irq_req_r, active_lvl_r, 1'b0, irq_src_r};
    irqp_prio_reg uut (
        .mclk                      (mclk),
        .reset                     (reset),
        .sfr_addr                  (sfr_addr),
        .sfr_wdata                 (sfr_wdata),
        .sfr_wr                    (sfr_wr),
        .sfr_rd                    (sfr_rd),
        .sfr_bit_wr                (sfr_bit_wr),
        .sfr_bit_sel               (sfr_bit_sel),
        .sfr_bit_val               (sfr_bit_val),
        .irq_pending               (irq_pending),
        .irq_enable                (irq_enable),
        .global_irq_enable         (global_irq_enable),
        .irq_ack                   (irq_ack),
        .irq_return                (irq_return),
        .sfr_rdata_r               (sfr_rdata_r),
        .sfr_hit_r                 (sfr_hit_r),
        .core_interrupt_priority_r (core_interrupt_priority_r),
        .irq_req_r                 (irq_req_r),
        .irq_src_r                 (irq_src_r),
        .irq_high_r                (irq_high_r),
        .active_lvl_r              (active_lvl_r)
    );
    always #25 mclk = ~mclk;
    function logic [7:0] lfsr(logic [7:0] x);
        return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
    endfunction
    task print_verdict;
        if (fails == 0 && num_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task chk(string n, logic [7:0] x, logic [7:0] g);
        num_checks++;
        if (x !== g) begin
            fails++;
            $display("Error %s expected %h seen %h", n, x, g);
        end
    endtask
    task wr(logic [7:0] a, logic [7:0] d);
        sfr_addr <= a; sfr_wdata <= d; sfr_wr <= 1; @(posedge mclk);
        sfr_wr <= 0; @(posedge mclk);
    endtask
    task bw(logic [2:0] b, logic v);
        sfr_addr <= `IRQP_PRIO_ADDR; sfr_bit_sel <= b; sfr_bit_val <= v; sfr_bit_wr <= 1;
        @(posedge mclk); sfr_bit_wr <= 0; @(posedge mclk);
    endtask
    task rd(logic [7:0] x);
        sfr_addr <= `IRQP_PRIO_ADDR; sfr_rd <= 1; q.push_back(x); @(posedge mclk);
        sfr_rd <= 0; @(posedge mclk);
    endtask
    // Status is sampled three cycles on, once the request logic has settled.
    task look(logic [7:0] x);
        qi.push_back(x); repeat (3) @(posedge mclk);
        snap <= 1; @(posedge mclk);
        snap <= 0;
    endtask
    // ****
    // Read results are compared as they appear.
    // ****
    always @(negedge mclk) if (sfr_hit_r === 1'b1) chk("rdata", q.pop_front(), sfr_rdata_r);
    always @(negedge mclk) if (snap === 1'b1) chk("irq", qi.pop_front(), stat);
    initial begin
        #1_000_000; fails++; print_verdict;
    end
    initial begin
        repeat (20) @(posedge mclk);
        reset <= 0; @(posedge mclk);
        rd(8'h80);
        for (i = 0; i < 8; i++) begin
            s = lfsr(s); wr(`IRQP_PRIO_ADDR, s); rd(s | 8'h80);
        end
        wr(`IRQP_IE_ADDR, 8'h00); bw(3'h7, 0); rd(s | 8'h80);
        wr(`IRQP_PRIO_ADDR, 8'h00);
        for (i = 0; i < 8; i++) begin
            bw(i, 1); e = 8'h80 | (8'h01 << i); rd(e);
            bw(i, 0); rd(8'h80);
        end
        wr(`IRQP_PRIO_ADDR, 8'h88); irq_enable <= 7'h7F; irq_pending <= 7'h09;
        global_irq_enable <= 1;
        look(8'hC3);
        irq_ack <= 1; @(posedge mclk); irq_ack <= 0;
        look(8'h20);
        irq_return <= 1; @(posedge mclk); irq_return <= 0; global_irq_enable <= 0;
        look(8'h00);
        global_irq_enable <= 1; irq_enable <= 7'h76; irq_pending <= 7'h0B;
        look(8'h41);
        irq_ack <= 1; @(posedge mclk); irq_ack <= 0; irq_enable <= 7'h7E;
        look(8'hD3);
        irq_ack <= 1; @(posedge mclk); irq_ack <= 0;
        look(8'h20);
        irq_return <= 1; irq_pending <= 7'h02; @(posedge mclk); irq_return <= 0;
        look(8'h10);
        print_verdict;
    end
endmodule // interrupt_priority_register_tb
